// ---- sdl_host_model.sv ----
/* sdl_host_model: host driving the serial link.
   assumes: 40 MHz core_clk_i, bit clock of 8 cycles. */
`timescale 1ns/100ps
module sdl_host_model (
  input  wire logic core_clk_i,
  output logic      select_n_o = 1'b1,
  output logic      bit_clk_o  = 1'b0,
  output logic      serial_o   = 1'b0,
  output logic      clear_n_o  = 1'b1
);
  // n bits msb first, clear level per bit
  task automatic send(input logic [15:0] w, input int n, input logic [15:0] c);
    select_n_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      serial_o  <= w[(15 - i) & 15];
      clear_n_o <= ~c[(15 - i) & 15];
      repeat (4) @(posedge core_clk_i);
      bit_clk_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      bit_clk_o <= 1'b0;
    end
    repeat (10) @(posedge core_clk_i);
    select_n_o <= 1'b1;
    clear_n_o  <= 1'b1;
    serial_o   <= ~serial_o;
    repeat (6) @(posedge core_clk_i);
  endtask : send
  // corrected code from two neighbouring table entries
  function automatic logic [15:0] correct(input logic [15:0] user_code,
    input logic [15:0] lower_table_entry, input logic [15:0] upper_table_entry);
    logic signed [16:0] diff;
    logic signed [23:0] prod;
    diff = $signed({1'b0, upper_table_entry}) - $signed({1'b0, lower_table_entry});
    prod = diff * $signed({18'h00000, user_code[5:0]});
    return lower_table_entry + prod[21:6];
  endfunction : correct
  // clock and data toggling while deselected
  task automatic noise();
    repeat (8) begin
      bit_clk_o <= ~bit_clk_o;
      serial_o  <= ~serial_o;
      repeat (4) @(posedge core_clk_i);
    end
  endtask : noise
endmodule : sdl_host_model

// ---- sdl_input_latch.sv ----
/*
  sdl_input_latch: serial word receiver and converter latch.
  assumes: link pins arrive asynchronously; bit clock well below core_clk_i/4.
*/
// Contract
// R1: a word is 16 bits, twos complement, most significant bit first.
// R2: after select falls, each rising bit-clock edge shifts the data bit in, msb first.
// R3: after the 16th rising edge, the next falling edge moves the word into the latch.
// R4: after the latch update further bit-clock edges are ignored until select cycles.
// R5: a select falling edge restarts reception with an empty bit count.
// R6: select rising before the update discards the partial word, latch unchanged.
// R7: while select is high, bit clock and data are ignored.
// R8: clear low in the 16th bit cycle loads midcode on the 16th falling edge.
// R9: clear high in the 16th bit cycle loads the shifted word on that edge.
// R10: releasing clear mid-transfer leaves midcode held until the next update.
// R11: clear does not disturb shifting; bits received meanwhile are kept.
// R12: latch codes 7FFF full positive, 4000 half, 0000 zero, BFFF and 8000 negative.
// R13: the host keeps the bit clock at or below 50 MHz.
// R14: host correction indexes a 1025-entry table by the top ten code bits.
// R15: host corrected code is entry plus difference times six low bits, shifted right 6.
// R16: after reset the latch holds midcode and the bit count is clear.
`timescale 1ns/100ps
module sdl_input_latch
  import sdl_pkg::*;
#(
  parameter int unsigned WORD_BITS = SDL_WORD_BITS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        select_n_i,
  input  wire logic        bit_clk_i,
  input  wire logic        serial_in_line_i,
  input  wire logic        force_midcode_n_i,
  output logic [15:0]      latch_code_o,
  output logic             latch_update_o,
  output logic             busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sel_s;
  logic sclk_s;
  logic serial_in_line_s;
  logic clr_s;

  sdl_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (select_n_i),
    .sync_o     (sel_s)
  );

  sdl_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (bit_clk_i),
    .sync_o     (sclk_s)
  );

  sdl_sync #(.RESET_VAL(1'b0)) u_sync_serial_in_line (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (serial_in_line_i),
    .sync_o     (serial_in_line_s)
  );

  sdl_sync #(.RESET_VAL(1'b1)) u_sync_clr (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (force_midcode_n_i),
    .sync_o     (clr_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  logic sel_d;
  logic sclk_d;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_d  <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      sel_d  <= sel_s;
      sclk_d <= sclk_s;
    end
  end

  logic sel_fall;
  logic sclk_rise;
  logic sclk_fall;

  assign sel_fall  = sel_d & ~sel_s;
  assign sclk_rise = ~sel_s & ~sclk_d & sclk_s;  // [R7]
  assign sclk_fall = ~sel_s & sclk_d & ~sclk_s;  // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // receive sequencer

  sdl_state_t state;
  logic [4:0] bit_cnt;
  logic [15:0] shift_reg;
  logic        clr_in_16th;
  logic        do_update;

  assign do_update = (state == SDL_SHIFT) && (bit_cnt == SDL_CNT_FULL) && sclk_fall;  // [R3]

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= SDL_IDLE;  // [R16]
    end else begin
      case (state)
        SDL_IDLE: begin
          if (sel_fall) begin
            state <= SDL_SHIFT;  // [R5]
          end
        end
        SDL_SHIFT: begin
          if (sel_s) begin
            state <= SDL_IDLE;  // [R6]
          end else if (do_update) begin
            state <= SDL_DONE;  // [R4]
          end
        end
        SDL_DONE: begin
          if (sel_s) begin
            state <= SDL_IDLE;  // [R4]
          end
        end
        default: begin
          state <= SDL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt <= SDL_CNT_RESET;  // [R16]
    end else if (sel_fall) begin
      bit_cnt <= SDL_CNT_RESET;  // [R5]
    end else if (state == SDL_SHIFT && sclk_rise && bit_cnt != SDL_CNT_FULL) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // shifting is independent of clear
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= SDL_LATCH_RESET;
    end else if (state == SDL_SHIFT && sclk_rise && bit_cnt != SDL_CNT_FULL) begin
      shift_reg <= {shift_reg[14:0], serial_in_line_s};  // [R1] [R2] [R11]
    end
  end

  // clear sampled from the 16th rising edge until the update
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clr_in_16th <= 1'b0;
    end else if (sel_fall) begin
      clr_in_16th <= 1'b0;
    end else if (state == SDL_SHIFT && bit_cnt == 5'h0F && sclk_rise) begin
      clr_in_16th <= ~clr_s;  // [R8]
    end else if (state == SDL_SHIFT && bit_cnt == SDL_CNT_FULL && !clr_s) begin
      clr_in_16th <= 1'b1;  // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter latch

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_code_o <= SDL_MIDCODE;  // [R16] [R12]
    end else if (do_update) begin
      if (clr_in_16th) begin
        latch_code_o <= SDL_MIDCODE;  // [R8] [R10]
      end else begin
        latch_code_o <= shift_reg;  // [R9]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_update_o <= 1'b0;
      busy_o         <= 1'b0;
    end else begin
      latch_update_o <= do_update;
      busy_o         <= (state == SDL_SHIFT) && !sel_s;
    end
  end

endmodule : sdl_input_latch

// ---- sdl_monitor.sv ----
/* sdl_monitor: port assertions of sdl_input_latch.
   assumes: bound to the design, one clock domain. */
`timescale 1ns/100ps
module sdl_monitor
  import sdl_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        select_n_i,
  input wire logic        force_midcode_n_i,
  input wire logic [15:0] latch_code_o,
  input wire logic        latch_update_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_PULSE: assert property (latch_update_o |=> !latch_update_o)
    else $error("long pulse");
  AST_CHG: assert property ($changed(latch_code_o) |-> latch_update_o)
    else $error("change without pulse");
  AST_END: assert property (latch_update_o |-> $past(busy_o, 2) ##1 !busy_o)
    else $error("busy at update");
  AST_HOLD: assert property (!busy_o && !$past(busy_o) |-> $stable(latch_code_o))
    else $error("latch moved idle");
  AST_IDLE: assert property (select_n_i [*8] |-> !busy_o && !latch_update_o)
    else $error("active deselected");
  AST_START: assert property ($fell(select_n_i) |-> ##[2:5] busy_o)
    else $error("no start");
  AST_ABORT: assert property ($rose(select_n_i) && busy_o |=> $stable(latch_code_o) [*6])
    else $error("abort moved latch");
  AST_CLR: assert property ((!force_midcode_n_i) [*8] ##1 latch_update_o |->
    latch_code_o == SDL_MIDCODE) else $error("no midcode");
  cover property (latch_update_o && latch_code_o == SDL_MIDCODE);
  cover property ($rose(select_n_i) && busy_o);
  cover property ($fell(select_n_i) ##[2:5] busy_o);
endmodule : sdl_monitor
bind sdl_input_latch sdl_monitor i_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .select_n_i(select_n_i), .force_midcode_n_i(force_midcode_n_i),
  .latch_code_o(latch_code_o), .latch_update_o(latch_update_o), .busy_o(busy_o));

// ---- sdl_pkg.sv ----
/*
  sdl_pkg: constants shared by the serial converter input latch.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package sdl_pkg;

  localparam int unsigned       SDL_WORD_BITS   = 16;
  localparam int unsigned       SDL_CNT_BITS    = 5;
  localparam logic [15:0]       SDL_MIDCODE     = 16'h0000;
  localparam logic [15:0]       SDL_LATCH_RESET = 16'h0000;
  localparam logic [4:0]        SDL_CNT_RESET   = 5'h00;
  localparam logic [4:0]        SDL_CNT_FULL    = 5'h10;
  localparam logic [1:0]        SDL_SYNC_RESET  = 2'h3;

  typedef enum logic [1:0] {
    SDL_IDLE,
    SDL_SHIFT,
    SDL_DONE
  } sdl_state_t;

endpackage : sdl_pkg

// ---- sdl_sync.sv ----
/*
  sdl_sync: two-flop synchroniser for one asynchronous level.
  assumes: input comes from outside core_clk_i's domain.
*/
`timescale 1ns/100ps
module sdl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : sdl_sync

// ---- tb_top.sv ----
/* tb_top: self-checking bench of sdl_input_latch.
   assumes: sdl_host_model drives the link pins. */
`timescale 1ns/100ps
module tb_top;
  import sdl_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sel_n, bclk, sdat, clr_n, upd, busy;
  logic [15:0] code, expv;
  logic [15:0] codes [5] = '{16'h7FFF, 16'h4000, 16'h0000, 16'hBFFF, 16'h8000};
  logic [31:0] rng = 32'h0000003F;
  int          errors = 0;
  int          samples_checked = 0;
  int          upd_cnt = 0;
  logic [15:0] correction_table [1025];
  logic [15:0] corr;
  always @(posedge core_clk) begin
    if (upd) begin
      upd_cnt++;
    end
  end
  always #12.5 core_clk = ~core_clk;
  sdl_host_model i_host (.core_clk_i(core_clk), .select_n_o(sel_n), .bit_clk_o(bclk),
    .serial_o(sdat), .clear_n_o(clr_n));
  sdl_input_latch i_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .select_n_i(sel_n),
    .bit_clk_i(bclk), .serial_in_line_i(sdat), .force_midcode_n_i(clr_n),
    .latch_code_o(code), .latch_update_o(upd), .busy_o(busy));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [15:0] exp_code(input logic [15:0] w, c, p, input int n);
    if (n < 16) return p;
    return c[0] ? SDL_MIDCODE : w;
  endfunction : exp_code
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input logic [15:0] w, input int n, input logic [15:0] c);
    upd_cnt = 0;
    i_host.send(w, n, c);
    expv = exp_code(w, c, expv, n);
    check(16'(upd_cnt), (n >= 16) ? 16'h0001 : 16'h0000);
    check(code, expv);
    check({15'h0000, busy}, 16'h0000);
  endtask : run
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    foreach (correction_table[k]) correction_table[k] = 16'(k * 64);
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    expv = SDL_LATCH_RESET;
    check(code, expv);
    foreach (codes[k]) run(codes[k], 16, 16'h0000);
    run(16'h1234, 10, 16'h0000);
    run(16'hA5C3, 17, 16'h0000);
    i_host.noise();
    run(16'h5A3C, 16, 16'h0001);
    run(16'hC3A5, 16, 16'h0400);
    corr = i_host.correct(16'h7FC1, correction_table[10'h1FF], correction_table[10'h200]);
    check(corr, 16'h7FC1);
    run(corr, 16, 16'h0000);
    for (int k = 0; k < 24; k++) begin
      rng = xs(rng);
      run(rng[15:0], 14 + int'(rng[17:16]), rng[31:16]);
    end
    stop_test();
  end
  initial begin
    #400us;
    errors++;
    stop_test();
  end
endmodule : tb_top
